// file: src/mtseq_core.sv
`timescale 1ns/1ps
module mtseq_core #(
  parameter int DELAY_AC_CYC = mtseq_pkg::DELAY_AC_CYC
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   cmd_valid,
  input  mtseq_pkg::mtseq_cmd_t       cmd,
  input  wire logic                   trig_in,
  input  wire logic                   line_50hz,
  input  wire logic                   mem_free,
  input  wire logic                   probe_done,
  input  wire logic [2:0]             probe_range,
  input  wire logic                   conv_done,
  input  wire logic [31:0]            conv_data,
  output mtseq_pkg::mtseq_state_t     state,
  output logic                        stale_err,
  output logic                        rd_valid,
  output logic [31:0]                 rd_data,
  output logic                        rd_last,
  output logic                        ext_grant,
  output logic                        ext_wr_valid,
  output logic [31:0]                 ext_wr_data,
  output logic                        probe_start,
  output logic                        conv_start,
  output mtseq_pkg::mtseq_chan_t      chan_out,
  output mtseq_pkg::mtseq_fn_t        meas_fn,
  output logic                        autorange,
  output logic [2:0]                  range_code,
  output mtseq_pkg::mtseq_res_t       res_sel,
  output logic [14:0]                 aperture_us,
  output logic                        power_cycle_integration,
  output logic                        auto_zero_setting,
  output logic                        offset_compensation,
  output logic                        trig_ext,
  output logic                        trig_count_auto,
  output logic                        delay_auto,
  output logic                        sample_ext,
  output logic [15:0]                 sample_count
);
  import mtseq_pkg::*;

  logic [31:0] mem [0:99];
  logic [15:0] tot;
  logic [6:0]  fidx;
  logic [15:0] smp;
  logic [23:0] dly_cnt;
  logic        ran;
  logic        fetch_pend;
  mtseq_list_t lst_kind;
  logic [6:0]  chan_first;
  logic [6:0]  chan_end;
  logic [6:0]  chan_cur;
  logic [6:0]  card;
  logic [2:0]  sel_range;
  logic        sel_auto;
  logic [14:0] sel_ap;
  logic        sel_plc;

  function automatic logic [6:0] bcd2(input logic [7:0] d);
    bcd2 = 7'({3'h0, d[7:4]} * 7'd10) + 7'({3'h0, d[3:0]});
  endfunction

  wire logic c_init  = cmd_valid && (cmd.op == OP_INIT || cmd.op == OP_READ || cmd.op == OP_MEASURE);
  wire logic c_read  = cmd_valid && (cmd.op == OP_READ || cmd.op == OP_MEASURE);
  wire logic c_meas  = cmd_valid && cmd.op == OP_MEASURE;
  wire logic c_abort = cmd_valid && cmd.op == OP_ABORT;
  wire logic c_reset = cmd_valid && cmd.op == OP_RESET;
  wire logic c_fetch = cmd_valid && cmd.op == OP_FETCH;
  wire logic stop    = c_abort || c_reset;

  wire logic start     = c_init && state == ST_IDLE && !stop;
  wire logic immediate = c_meas || !trig_ext;
  wire logic fetch_go  = c_fetch && state == ST_IDLE && ran && !stop;

  wire logic [6:0] dec_a = bcd2(cmd.chan_a[7:0]);
  wire logic [6:0] dec_b = bcd2(cmd.chan_b[7:0]);
  wire logic [6:0] cur_first = c_meas ? dec_a : chan_first;

  wire logic chan_done = (lst_kind == CL_RANGE || lst_kind == CL_COMMA) ? (chan_cur == chan_end) : 1'b1;
  wire logic smp_done  = (smp + 16'h0001) >= sample_count;
  wire logic rd_done   = conv_done && state == ST_CONV;
  wire logic last_rd   = smp_done && chan_done;

  wire logic [6:0] stored    = (tot >= {9'h0, MEM_DEPTH}) ? MEM_DEPTH : tot[6:0];
  wire logic       fetch_end = (fidx + 7'd1) >= stored;

  wire logic dly_zero    = dly_cnt == 24'h0;
  wire logic enter_delay = !stop && ((start && immediate) || (state == ST_WAIT && trig_in) || (rd_done && !last_rd));
  wire logic enter_probe = !stop && state == ST_DELAY && dly_zero && autorange;
  wire logic enter_conv  = !stop && ((state == ST_DELAY && dly_zero && !autorange) ||
                                     (state == ST_PROBE && probe_done));
  wire logic enter_fetch = !stop && (fetch_go || (rd_done && last_rd && fetch_pend));
  wire mtseq_fn_t dly_fn = c_meas ? cmd.fn : meas_fn;

  mtseq_range_sel u_range_sel (
    .range_kind  (cmd.range_kind),
    .range_ohms  (cmd.range_ohms),
    .res_kind    (cmd.res_kind),
    .ap_req      (cmd.ap_req),
    .line_50hz   (line_50hz),
    .range_code  (sel_range),
    .autorange   (sel_auto),
    .aperture_us (sel_ap),
    .plc_mode    (sel_plc)
  );

  // Sequencer; abort and reset win over every other event
  always_ff @(posedge clock) begin
    if (rst || stop) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          // Trigger has no path out of idle
          if (start) state <= immediate ? ST_DELAY : ST_WAIT;
          else if (fetch_go) state <= ST_FETCH;
        end
        ST_WAIT: begin
          if (trig_in) state <= ST_DELAY;
        end
        ST_DELAY: begin
          if (dly_zero) state <= autorange ? ST_PROBE : ST_CONV;
        end
        ST_PROBE: begin
          if (probe_done) state <= ST_CONV;
        end
        ST_CONV: begin
          // Run ends in idle, or in fetch when a fetch is pending; host must initiate again
          if (conv_done) state <= !last_rd ? ST_DELAY : (fetch_pend ? ST_FETCH : ST_IDLE);
        end
        ST_FETCH: begin
          if (fetch_end) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || stop) begin
      ran <= 1'b0;
      fetch_pend <= 1'b0;
    end else begin
      if (start) ran <= 1'b1;
      if (enter_fetch) fetch_pend <= 1'b0;
      else if (start && c_read) fetch_pend <= 1'b1;
      else if (c_fetch && state != ST_IDLE && state != ST_FETCH) fetch_pend <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stale_err <= 1'b0;
    end else begin
      stale_err <= c_fetch && !stop && state == ST_IDLE && !ran;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dly_cnt <= 24'h0;
    end else if (enter_delay) begin
      dly_cnt <= (dly_fn == FN_ACV) ? 24'(DELAY_AC_CYC - 1) : 24'h0;
    end else if (state == ST_DELAY && !dly_zero) begin
      dly_cnt <= dly_cnt - 24'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      probe_start <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      probe_start <= enter_probe;
      conv_start <= enter_conv;
    end
  end

  // Configuration; measure loads its one-shot defaults
  always_ff @(posedge clock) begin
    if (rst || c_reset) begin
      meas_fn <= FN_DCV;
      autorange <= 1'b1;
      range_code <= RNG_MIN;
      res_sel <= RS_DEF;
      aperture_us <= AP_60HZ_US;
      power_cycle_integration <= 1'b1;
      auto_zero_setting <= 1'b1;
      offset_compensation <= 1'b0;
      trig_ext <= 1'b0;
      trig_count_auto <= 1'b1;
      delay_auto <= 1'b1;
      sample_ext <= 1'b0;
      sample_count <= SAMPLES_MEAS;
    end else begin
      if (c_meas) begin
        meas_fn <= cmd.fn;
        autorange <= sel_auto;
        if (!sel_auto) range_code <= sel_range;
        res_sel <= cmd.res_kind;
        aperture_us <= sel_ap;
        power_cycle_integration <= sel_plc;
        auto_zero_setting <= 1'b1;
        offset_compensation <= 1'b0;
        trig_ext <= 1'b0;
        trig_count_auto <= 1'b1;
        delay_auto <= 1'b1;
        sample_ext <= 1'b0;
        sample_count <= SAMPLES_MEAS;
      end else if (cmd_valid && cmd.op == OP_TRIG_SRC && state == ST_IDLE) begin
        trig_ext <= cmd.value[0];
      end else if (cmd_valid && cmd.op == OP_SAMPLES && state == ST_IDLE && cmd.value != 16'h0) begin
        sample_count <= cmd.value;
      end
      if (state == ST_PROBE && probe_done && !stop) range_code <= probe_range;
    end
  end

  // Channel scan
  always_ff @(posedge clock) begin
    if (rst || c_reset) begin
      lst_kind <= CL_NONE;
      chan_first <= 7'h0;
      chan_end <= 7'h0;
      chan_cur <= 7'h0;
      card <= 7'h0;
      smp <= 16'h0;
    end else begin
      if (c_meas) begin
        lst_kind <= cmd.list_kind;
        chan_first <= dec_a;
        chan_end <= (cmd.list_kind == CL_SINGLE) ? dec_a : dec_b;
        card <= bcd2(cmd.chan_a[15:8]);
      end
      if (start) begin
        chan_cur <= cur_first;
        smp <= 16'h0;
      end else if (rd_done) begin
        if (!smp_done) begin
          smp <= smp + 16'h0001;
        end else begin
          smp <= 16'h0;
          if (!chan_done) chan_cur <= (lst_kind == CL_COMMA) ? chan_end : chan_cur + 7'd1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      chan_out <= '0;
    end else begin
      chan_out.valid <= lst_kind != CL_NONE && state != ST_IDLE && state != ST_FETCH;
      chan_out.four_wire <= meas_fn == FN_FOHMS;
      chan_out.card <= card;
      chan_out.sense <= chan_cur;
      chan_out.source <= (meas_fn == FN_FOHMS) ? chan_cur + PAIR_OFFSET : chan_cur;
    end
  end

  // Reading store; a new run restarts at slot zero
  always_ff @(posedge clock) begin
    if (rst) begin
      tot <= 16'h0;
      ext_grant <= 1'b0;
      ext_wr_valid <= 1'b0;
      ext_wr_data <= 32'h0;
    end else begin
      ext_wr_valid <= 1'b0;
      if (start) begin
        tot <= 16'h0;
        ext_grant <= !c_meas && sample_count > {9'h0, MEM_DEPTH} && mem_free;
      end else if (rd_done && !stop) begin
        if (tot != 16'hFFFF) tot <= tot + 16'h0001;
        if (tot >= {9'h0, MEM_DEPTH} && ext_grant) begin
          ext_wr_valid <= 1'b1;
          ext_wr_data <= conv_data;
        end
      end
    end
  end

  // Memory itself has no reset; tot marks what is valid
  always_ff @(posedge clock) begin
    if (rd_done && !stop && tot < {9'h0, MEM_DEPTH}) mem[tot[6:0]] <= conv_data;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      fidx <= 7'h0;
      rd_valid <= 1'b0;
      rd_last <= 1'b0;
      rd_data <= 32'h0;
    end else begin
      rd_valid <= 1'b0;
      rd_last <= 1'b0;
      if (enter_fetch) begin
        fidx <= 7'h0;
      end else if (state == ST_FETCH && !stop && fidx < stored) begin
        rd_valid <= 1'b1;
        rd_data <= mem[fidx];
        rd_last <= fetch_end;
        fidx <= fidx + 7'd1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_init_waits: assert property (start && trig_ext && !c_meas |=> state == ST_WAIT)
    else $error("initiate did not wait for trigger");
  a_trig_runs: assert property (state == ST_WAIT && trig_in && !stop |=> state == ST_DELAY)
    else $error("trigger did not start measurement");
  a_imm_start: assert property (start && immediate |=> state == ST_DELAY && tot == 16'h0)
    else $error("immediate source did not start fresh run");
  a_abort_idle: assert property (c_abort |=> state == ST_IDLE && !ran)
    else $error("abort left block busy");
  a_ext_route: assert property (rd_done && !stop && ext_grant && tot >= 16'd100 |=> ext_wr_valid)
    else $error("extra reading not routed out");
  a_read_fetch: assert property (start && c_read |=> fetch_pend)
    else $error("read did not request fetch");
  a_reset_idle: assert property (c_reset |=> state == ST_IDLE && sample_count == 16'h1)
    else $error("reset command not idle");
  a_zero_on: assert property (c_meas && !stop |=> auto_zero_setting && !offset_compensation)
    else $error("measure zero settings wrong");
  a_meas_trig: assert property (c_meas && !stop |=> !trig_ext && !sample_ext && sample_count == 16'h1)
    else $error("measure trigger defaults wrong");
  a_ac_delay: assert property (enter_delay && dly_fn == FN_ACV |=> dly_cnt == 24'(DELAY_AC_CYC - 1))
    else $error("AC delay not loaded");
  a_probe_first: assert property (enter_probe |=> probe_start ##0 state == ST_PROBE)
    else $error("autorange probe skipped");
  a_fast_clamp: assert property (autorange |-> aperture_us != AP_FIXED_MIN_US)
    else $error("fixed-range aperture while autoranging");
  a_pair_chan: assert property (chan_out.four_wire |-> chan_out.source == chan_out.sense + PAIR_OFFSET)
    else $error("four-wire pair offset wrong");
  a_stale_err: assert property (c_fetch && !stop && state == ST_IDLE && !ran |=> stale_err && state == ST_IDLE)
    else $error("stale fetch not flagged");
  a_trig_idle: assert property (state == ST_IDLE && trig_in && !cmd_valid |=> state == ST_IDLE && $stable(tot))
    else $error("idle trigger changed state");

  c_ext_run: cover property (state == ST_WAIT ##1 state == ST_DELAY ##[1:20] state == ST_CONV);
  c_measure: cover property (c_meas ##[1:50] rd_valid && rd_last);
  c_stale: cover property (stale_err);
  c_abort_wait: cover property (state == ST_WAIT && c_abort);
endmodule

// file: src/mtseq_pkg.sv
package mtseq_pkg;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_INIT = 4'h1, OP_ABORT = 4'h2, OP_RESET = 4'h3, OP_FETCH = 4'h4,
    OP_READ = 4'h5, OP_MEASURE = 4'h6, OP_TRIG_SRC = 4'h7, OP_SAMPLES = 4'h8
  } mtseq_op_t;

  typedef enum logic [1:0] {FN_DCV = 2'h0, FN_ACV = 2'h1, FN_OHMS = 2'h2, FN_FOHMS = 2'h3} mtseq_fn_t;

  typedef enum logic [2:0] {
    RG_OMIT = 3'h0, RG_AUTO = 3'h1, RG_DEF = 3'h2, RG_MIN = 3'h3, RG_MAX = 3'h4, RG_VALUE = 3'h5
  } mtseq_rng_t;

  typedef enum logic [1:0] {RS_DEF = 2'h0, RS_MIN = 2'h1, RS_MAX = 2'h2, RS_VALUE = 2'h3} mtseq_res_t;
  typedef enum logic [1:0] {AQ_PLC = 2'h0, AQ_100US = 2'h1, AQ_10US = 2'h2} mtseq_ap_t;
  typedef enum logic [1:0] {CL_NONE = 2'h0, CL_SINGLE = 2'h1, CL_COMMA = 2'h2, CL_RANGE = 2'h3} mtseq_list_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WAIT = 3'b001, ST_DELAY = 3'b010, ST_PROBE = 3'b011, ST_CONV = 3'b100, ST_FETCH = 3'b101
  } mtseq_state_t;

  typedef struct packed {
    mtseq_op_t   op;
    mtseq_fn_t   fn;
    mtseq_rng_t  range_kind;
    logic [20:0] range_ohms;
    mtseq_res_t  res_kind;
    mtseq_ap_t   ap_req;
    mtseq_list_t list_kind;
    logic [15:0] chan_a;
    logic [15:0] chan_b;
    logic [15:0] value;
  } mtseq_cmd_t;

  typedef struct packed {
    logic       valid;
    logic       four_wire;
    logic [6:0] card;
    logic [6:0] sense;
    logic [6:0] source;
  } mtseq_chan_t;

  localparam int          CLK_HZ        = 20_000_000;
  localparam int          DELAY_AC_MS   = 500;
  localparam int          DELAY_AC_CYC  = DELAY_AC_MS * (CLK_HZ / 1000);
  localparam logic [6:0]  MEM_DEPTH     = 7'd100;
  localparam logic [15:0] SAMPLES_MEAS  = 16'h0001;
  localparam logic [6:0]  PAIR_OFFSET   = 7'd8;
  localparam logic [20:0] OHM_232       = 21'd232;
  localparam logic [20:0] OHM_1861      = 21'd1861;
  localparam logic [20:0] OHM_14894     = 21'd14894;
  localparam logic [20:0] OHM_119156    = 21'd119156;
  localparam logic [2:0]  RNG_MIN       = 3'h0;
  localparam logic [2:0]  RNG_MAX       = 3'h4;
  localparam logic [14:0] AP_60HZ_US    = 15'd16700;
  localparam logic [14:0] AP_50HZ_US    = 15'd20000;
  localparam logic [14:0] AP_AUTO_MIN_US = 15'd100;
  localparam logic [14:0] AP_FIXED_MIN_US = 15'd10;

endpackage

// file: src/mtseq_range_sel.sv
`timescale 1ns/1ps
module mtseq_range_sel (
  input  wire mtseq_pkg::mtseq_rng_t range_kind,
  input  wire logic [20:0] range_ohms,
  input  wire mtseq_pkg::mtseq_res_t res_kind,
  input  wire mtseq_pkg::mtseq_ap_t  ap_req,
  input  wire logic        line_50hz,
  output logic [2:0]       range_code,
  output logic             autorange,
  output logic [14:0]      aperture_us,
  output logic             plc_mode
);
  import mtseq_pkg::*;

  always_comb begin
    autorange = (range_kind == RG_OMIT) || (range_kind == RG_AUTO) || (range_kind == RG_DEF);
    range_code = RNG_MIN;
    if (range_kind == RG_MAX) begin
      range_code = RNG_MAX;
    end else if (range_kind == RG_VALUE) begin
      // Value is the largest expected input
      if (range_ohms <= OHM_232) range_code = 3'h0;
      else if (range_ohms <= OHM_1861) range_code = 3'h1;
      else if (range_ohms <= OHM_14894) range_code = 3'h2;
      else if (range_ohms <= OHM_119156) range_code = 3'h3;
      else range_code = RNG_MAX;
    end
  end

  always_comb begin
    plc_mode = 1'b1;
    aperture_us = line_50hz ? AP_50HZ_US : AP_60HZ_US;
    if (res_kind != RS_DEF) begin
      if (ap_req == AQ_10US) begin
        plc_mode = 1'b0;
        aperture_us = autorange ? AP_AUTO_MIN_US : AP_FIXED_MIN_US;
      end else if (ap_req == AQ_100US) begin
        plc_mode = 1'b0;
        aperture_us = AP_AUTO_MIN_US;
      end
    end
  end
endmodule

// file: tb/mtseq_fe_model.sv
`timescale 1ns/1ps
module mtseq_fe_model #(
  parameter logic [31:0] FIRST_DATA = 32'h0000_0000
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  lat,
  input  wire logic [2:0]  pick,
  input  wire logic        probe_start,
  input  wire logic        conv_start,
  output logic             probe_done = 1'b0,
  output logic [2:0]       probe_range = 3'h0,
  output logic             conv_done = 1'b0,
  output logic [31:0]      conv_data = 32'h0
);
  logic [3:0]  pcnt = 4'h0;
  logic [3:0]  ccnt = 4'h0;
  logic [31:0] seq = 32'h0;

  // Data lines flip between answers so a late sample never matches
  always @(negedge clock) begin
    probe_done <= 1'b0;
    conv_done <= 1'b0;
    probe_range <= ~probe_range;
    conv_data <= ~conv_data;
    if (rst) begin
      pcnt <= 4'h0;
      ccnt <= 4'h0;
      seq <= FIRST_DATA;
    end else begin
      if (pcnt == 4'h1) begin
        probe_done <= 1'b1;
        probe_range <= pick;
      end
      if (ccnt == 4'h1) begin
        conv_done <= 1'b1;
        conv_data <= seq;
        seq <= seq + 32'h1;
      end
      pcnt <= probe_start ? lat : ((pcnt != 4'h0) ? pcnt - 4'h1 : 4'h0);
      ccnt <= conv_start ? lat : ((ccnt != 4'h0) ? ccnt - 4'h1 : 4'h0);
    end
  end
endmodule

// file: tb/test_measurement_trigger_sequencer.sv
`timescale 1ns/1ps
module test_measurement_trigger_sequencer;
  import mtseq_pkg::*;
  localparam int          ACD   = 20;
  localparam int          LIMIT = 20000;
  localparam logic [31:0] BASE  = 32'h5A00_0000;
  logic         clock     = 1'b0;
  logic         rst       = 1'b1;
  logic         cmd_valid = 1'b0;
  mtseq_cmd_t   cmd       = '0;
  logic         trig_in   = 1'b0;
  logic         line_50hz = 1'b0;
  logic         mem_free  = 1'b0;
  logic [3:0]   lat       = 4'h6;
  logic [2:0]   pick      = 3'h3;
  logic         probe_done, conv_done, stale_err, rd_valid, rd_last, ext_grant, ext_wr_valid;
  logic         probe_start, conv_start, autorange, power_cycle_integration, auto_zero_setting;
  logic         offset_compensation, trig_ext, trig_count_auto, delay_auto, sample_ext;
  logic [2:0]   probe_range, range_code;
  logic [31:0]  conv_data, rd_data, ext_wr_data, ext_seen;
  logic [14:0]  aperture_us;
  logic [15:0]  sample_count;
  mtseq_state_t state;
  mtseq_chan_t  chan_out;
  mtseq_fn_t    meas_fn;
  mtseq_res_t   res_sel;
  logic [31:0]  rdq[$];
  int           fail_count, checks_done, cyc, stale_n, pr_n, cs_n, ext_n, dl_n, last_n, n0, n1;
  mtseq_rng_t   t_rk[8]  = '{RG_OMIT, RG_AUTO, RG_DEF, RG_MIN, RG_MAX, RG_VALUE, RG_VALUE, RG_VALUE};
  logic [20:0]  t_ohm[8] = '{21'h0, 21'h0, 21'h0, 21'h0, 21'h0, 21'h528, 21'hE8, 21'h1D175};
  mtseq_res_t   t_res[8] = '{RS_DEF, RS_VALUE, RS_DEF, RS_MIN, RS_MAX, RS_VALUE, RS_VALUE, RS_DEF};
  mtseq_ap_t    t_ap[8]  = '{AQ_PLC, AQ_10US, AQ_PLC, AQ_PLC, AQ_PLC, AQ_10US, AQ_100US, AQ_PLC};
  logic [2:0]   t_rc[8]  = '{3'h0, 3'h0, 3'h0, RNG_MIN, RNG_MAX, 3'h1, RNG_MIN, RNG_MAX};
  logic [14:0]  t_ape[8] = '{AP_60HZ_US, AP_AUTO_MIN_US, AP_50HZ_US, AP_60HZ_US, AP_60HZ_US,
                             AP_FIXED_MIN_US, AP_AUTO_MIN_US, AP_50HZ_US};
  logic [7:0]   t_l50    = 8'h84;
  logic [7:0]   t_auto   = 8'h07;

  mtseq_core #(.DELAY_AC_CYC(ACD)) uut (
    .clock, .rst, .cmd_valid, .cmd, .trig_in, .line_50hz, .mem_free, .probe_done, .probe_range,
    .conv_done, .conv_data, .state, .stale_err, .rd_valid, .rd_data, .rd_last, .ext_grant,
    .ext_wr_valid, .ext_wr_data, .probe_start, .conv_start, .chan_out, .meas_fn, .autorange,
    .range_code, .res_sel, .aperture_us, .power_cycle_integration, .auto_zero_setting,
    .offset_compensation, .trig_ext, .trig_count_auto, .delay_auto, .sample_ext, .sample_count
  );
  mtseq_fe_model #(.FIRST_DATA(BASE)) fe (
    .clock, .rst, .lat, .pick, .probe_start, .conv_start, .probe_done, .probe_range, .conv_done,
    .conv_data
  );

  initial forever #25 clock = ~clock;

  // Outputs settle by the falling edge, so all watching happens there
  always @(negedge clock) begin
    cyc++;
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (rd_valid === 1'b1 && rd_last === 1'b1) last_n++;
    if (stale_err === 1'b1) stale_n++;
    if (probe_start === 1'b1) pr_n++;
    if (conv_start === 1'b1) cs_n++;
    if (ext_wr_valid === 1'b1) begin
      ext_n++;
      ext_seen = ext_wr_data;
    end
    if (state === ST_DELAY) dl_n++;
    if (cyc == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic send(input mtseq_op_t op);
    @(negedge clock);
    cmd.op <= op;
    cmd_valid <= 1'b1;
    @(negedge clock);
    cmd_valid <= 1'b0;
  endtask

  task automatic finish_run();
    for (int k = 0; k < 4000 && state !== ST_IDLE; k++) @(negedge clock);
    // One more edge so the watcher has logged the last reading
    tick(1);
    chk(state, ST_IDLE);
  endtask

  task automatic pulse_trig();
    trig_in <= 1'b1;
    tick(1);
    trig_in <= 1'b0;
  endtask

  task automatic fetch_chk(input int n, input logic [31:0] first);
    rdq.delete();
    n1 = last_n;
    send(OP_FETCH);
    finish_run();
    chk(rdq.size(), n);
    chk(rdq[0], first);
    chk(rdq[n - 1], first + n - 1);
    chk(last_n - n1, 1);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    tick(10);
    rst <= 1'b0;
    tick(1);
  endtask

  initial begin
    tick(1);
    do_reset();
    chk(state, ST_IDLE);
    chk({autorange, power_cycle_integration, aperture_us}, {2'b11, AP_60HZ_US});
    n0 = stale_n;
    send(OP_FETCH);
    tick(3);
    chk(stale_n - n0, 1);
    n0 = cs_n;
    pulse_trig();
    tick(3);
    chk(state, ST_IDLE);
    chk(cs_n - n0, 0);
    $display("test idle_after_reset done");
    // Slow front end so each abort lands mid-run
    for (int i = 0; i < 8; i++) begin
      cmd <= '{op: OP_NONE, fn: FN_OHMS, range_kind: t_rk[i], range_ohms: t_ohm[i], res_kind: t_res[i],
               ap_req: t_ap[i], list_kind: CL_SINGLE, chan_a: 16'h0105, chan_b: 16'h0, value: 16'h0};
      line_50hz <= t_l50[i];
      send(OP_MEASURE);
      chk(autorange, t_auto[i]);
      if (!t_auto[i]) chk(range_code, t_rc[i]);
      chk({power_cycle_integration, aperture_us}, {t_ape[i] >= AP_60HZ_US, t_ape[i]});
      chk({meas_fn, res_sel}, {FN_OHMS, t_res[i]});
      chk({auto_zero_setting, offset_compensation, trig_ext, sample_ext}, 4'h8);
      chk({trig_count_auto, delay_auto, sample_count}, {2'b11, SAMPLES_MEAS});
      // Channel outputs lag the loaded list by one edge
      tick(1);
      chk({chan_out.card, chan_out.sense}, {7'h01, 7'h05});
      send(OP_ABORT);
      chk(state, ST_IDLE);
      tick(8);
    end
    $display("test range_select done");
    lat <= 4'h1;
    line_50hz <= 1'b0;
    do_reset();
    rdq.delete();
    n0 = dl_n;
    cmd <= '{OP_NONE, FN_DCV, RG_MIN, 21'h0, RS_DEF, AQ_PLC, CL_SINGLE, 16'h0105, 16'h0, 16'h0};
    send(OP_MEASURE);
    finish_run();
    chk(rdq.size(), 1);
    chk(rdq[0], BASE);
    chk(dl_n - n0, 1);
    $display("test measure_dc done");
    lat <= 4'h3;
    rdq.delete();
    n0 = pr_n;
    cmd <= '{OP_NONE, FN_FOHMS, RG_AUTO, 21'h0, RS_MIN, AQ_10US, CL_COMMA, 16'h0102, 16'h0106, 16'h0};
    send(OP_MEASURE);
    tick(1);
    chk({chan_out.valid, chan_out.four_wire, chan_out.card}, {2'b11, 7'h01});
    chk({chan_out.sense, chan_out.source}, {7'h02, 7'h02 + PAIR_OFFSET});
    chk(aperture_us, AP_AUTO_MIN_US);
    finish_run();
    chk(pr_n - n0, 2);
    chk(range_code, pick);
    chk(rdq.size(), 2);
    chk(rdq[1], BASE + 2);
    $display("test four_wire_auto done");
    lat <= 4'h1;
    mem_free <= 1'b1;
    do_reset();
    cmd.value <= 16'h0065;
    send(OP_SAMPLES);
    cmd.value <= 16'h0001;
    send(OP_TRIG_SRC);
    chk({trig_ext, sample_count}, {1'b1, 16'h0065});
    n0 = ext_n;
    send(OP_INIT);
    tick(5);
    chk(state, ST_WAIT);
    chk(ext_grant, 1'b1);
    pulse_trig();
    finish_run();
    chk(ext_n - n0, 1);
    chk(ext_seen, BASE + 32'd100);
    fetch_chk(100, BASE);
    pulse_trig();
    tick(3);
    chk(state, ST_IDLE);
    fetch_chk(100, BASE);
    send(OP_INIT);
    tick(2);
    chk(state, ST_WAIT);
    send(OP_ABORT);
    chk(state, ST_IDLE);
    n0 = stale_n;
    send(OP_FETCH);
    tick(3);
    chk(stale_n - n0, 1);
    send(OP_INIT);
    send(OP_RESET);
    chk({state, trig_ext, sample_count}, {ST_IDLE, 1'b0, 16'h0001});
    $display("test external_trigger done");
    mem_free <= 1'b0;
    n0 = dl_n;
    cmd <= '{OP_NONE, FN_ACV, RG_MAX, 21'h0, RS_DEF, AQ_PLC, CL_SINGLE, 16'h0203, 16'h0, 16'h0};
    send(OP_MEASURE);
    finish_run();
    chk(dl_n - n0, ACD);
    rdq.delete();
    send(OP_READ);
    finish_run();
    chk(rdq.size(), 1);
    $display("test ac_delay_read done");
    rdq.delete();
    n0 = cs_n;
    cmd <= '{OP_NONE, FN_OHMS, RG_MIN, 21'h0, RS_DEF, AQ_PLC, CL_RANGE, 16'h0104, 16'h0106, 16'h0};
    send(OP_MEASURE);
    finish_run();
    chk(rdq.size(), 3);
    chk(cs_n - n0, 3);
    chk({chan_out.four_wire, chan_out.sense, chan_out.card}, {1'b0, 7'h06, 7'h01});
    $display("test channel_range done");
    conclude();
  end
endmodule
